// >>> common/plld_pkg.sv
// constants, types and helpers of the pll lock detector.
// assumes one 125 mhz clock; phase detector edges arrive as one-cycle pulses.
package plld_pkg;
    // ==========================================
    // register map
    localparam logic [5:0] REG_LD_CTRL = 6'h07;
    localparam logic [5:0] REG_PIN_CFG = 6'h0f;
    localparam logic [5:0] REG_STATUS = 6'h12;
    localparam logic [23:0] LD_CTRL_RST = 24'h00014d;
    localparam logic [23:0] PIN_CFG_RST = 24'h000001;
    localparam logic [23:0] CTRL_RW_MASK = 24'h000fcf;
    localparam logic [23:0] PIN_RW_MASK = 24'h00005f;
    // ==========================================
    // field positions
    localparam int THR_LSB = 0;
    localparam int EN_BIT = 3;
    localparam int WTYPE_BIT = 6;
    localparam int DUR_LSB = 7;
    localparam int SPD_LSB = 10;
    localparam int PIN_SRC_LSB = 0;
    localparam int PIN_SHARE_BIT = 6;
    localparam int STAT_LOCK_BIT = 1;
    localparam logic [4:0] PIN_SRC_LOCK = 5'h01;
    // ==========================================
    // timing
    localparam int CLK_PERIOD_NS = 8;
    localparam int ANALOG_WIN_NS = 10;
    // longest time: round down, never below one cycle
    localparam int ANALOG_WIN_CYC_I = (ANALOG_WIN_NS / CLK_PERIOD_NS < 1) ? 1 :
                                      ANALOG_WIN_NS / CLK_PERIOD_NS;
    localparam logic [7:0] ANALOG_WIN_CYC = 8'(ANALOG_WIN_CYC_I);
    // ==========================================
    // serial frame: rw bit, 6 address bits, 24 data bits
    localparam logic [4:0] SER_ADDR_LAST = 5'h06;
    localparam logic [4:0] SER_DATA_LAST = 5'h1e;
    localparam logic [4:0] SER_BIT_MAX = 5'h1f;
    // ==========================================
    // comparison states, gray only between idle and CMP_WAIT_DIV
    typedef enum logic [1:0] {
        CMP_IDLE = 2'b00,
        CMP_WAIT_DIV = 2'b01,
        CMP_WAIT_REF = 2'b11
    } plld_cmp_type;

    function automatic logic [16:0] plld_thresh(input logic [2:0] code);
        logic [16:0] t;
        t = 17'h00005;
        unique case (code)
            3'h0: t = 17'h00005;
            3'h1: t = 17'h00020;
            3'h2: t = 17'h00060;
            3'h3: t = 17'h00100;
            3'h4: t = 17'h00200;
            3'h5: t = 17'h00800;
            3'h6: t = 17'h02000;
            3'h7: t = 17'h0ffff;
        endcase
        return t;
    endfunction

    function automatic logic [23:0] plld_read(input logic [5:0] addr,
                                              input logic [23:0] ctrl,
                                              input logic [23:0] pin,
                                              input logic lock);
        logic [23:0] d;
        d = 24'h000000;
        if (addr == REG_LD_CTRL) begin
            d = ctrl;
        end else if (addr == REG_PIN_CFG) begin
            d = pin;
        end else if (addr == REG_STATUS) begin
            d[STAT_LOCK_BIT] = lock;
        end
        return d;
    endfunction
endpackage

// >>> src/plld_serial_port.sv
// serial register port: rw bit, address, 24 data bits, msb first.
// assumes ser_clk is already synchronous to clock and slow (>=2 clocks per half).
`timescale 1ns/10ps
module plld_serial_port
    import plld_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic nrst,
    // serial pins
    input wire logic ser_clk,
    input wire logic ser_en,
    input wire logic ser_din,
    // register side
    input wire logic [23:0] rdata,
    output logic wr_pulse,
    output logic [5:0] addr,
    output logic [23:0] wdata,
    output logic rd_active,
    output logic sdo
);
    // ==========================================
    // frame state
    logic sclk_q_r, sclk_q_nxt;
    logic [4:0] bit_r, bit_nxt;
    logic rw_r, rw_nxt;
    logic [5:0] addr_r, addr_nxt;
    logic [23:0] shift_r, shift_nxt;
    logic load_r, load_nxt;
    logic wr_r, wr_nxt;
    logic rd_r, rd_nxt;
    logic sdo_r, sdo_nxt;
    logic rise;

    always_comb begin
        rise = ser_en & ser_clk & ~sclk_q_r;
        sclk_q_nxt = ser_clk;
        bit_nxt = bit_r;
        rw_nxt = rw_r;
        addr_nxt = addr_r;
        shift_nxt = shift_r;
        load_nxt = 1'b0;
        wr_nxt = 1'b0;
        rd_nxt = rd_r;
        sdo_nxt = sdo_r;
        if (!ser_en) begin
            bit_nxt = 5'h00;
            rd_nxt = 1'b0;
            sdo_nxt = 1'b0;
        end else if (load_r) begin
            // read data fetched one cycle after the address settles
            shift_nxt = rdata;
            sdo_nxt = rdata[23];
        end else if (rise) begin
            if (bit_r != SER_BIT_MAX) begin
                bit_nxt = 5'(bit_r + 5'h01);
            end
            if (bit_r == 5'h00) begin
                rw_nxt = ser_din;
            end else if (bit_r <= SER_ADDR_LAST) begin
                addr_nxt = {addr_r[4:0], ser_din};
                if (bit_r == SER_ADDR_LAST && rw_r) begin
                    load_nxt = 1'b1;
                    rd_nxt = 1'b1;
                end
            end else if (rw_r) begin
                shift_nxt = {shift_r[22:0], 1'b0};
                sdo_nxt = shift_r[22];
            end else if (bit_r <= SER_DATA_LAST) begin
                shift_nxt = {shift_r[22:0], ser_din};
                wr_nxt = (bit_r == SER_DATA_LAST);
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            sclk_q_r <= 1'b0;
            bit_r <= 5'h00;
            rw_r <= 1'b0;
            addr_r <= 6'h00;
            shift_r <= 24'h000000;
            load_r <= 1'b0;
            wr_r <= 1'b0;
            rd_r <= 1'b0;
            sdo_r <= 1'b0;
        end else begin
            sclk_q_r <= sclk_q_nxt;
            bit_r <= bit_nxt;
            rw_r <= rw_nxt;
            addr_r <= addr_nxt;
            shift_r <= shift_nxt;
            load_r <= load_nxt;
            wr_r <= wr_nxt;
            rd_r <= rd_nxt;
            sdo_r <= sdo_nxt;
        end
    end

    assign wr_pulse = wr_r;
    assign addr = addr_r;
    assign wdata = shift_r;
    assign rd_active = rd_r;
    assign sdo = sdo_r;
endmodule

// >>> src/plld_lock_detect.sv
// pll lock detector: window timing, consecutive count, lock pin sharing.
// assumes ref_edge and div_edge are one-cycle pulses synchronous to clock.
`timescale 1ns/10ps
module plld_lock_detect
    import plld_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic nrst,
    // serial port
    input wire logic ser_clk,
    input wire logic ser_en,
    input wire logic ser_din,
    // phase detector edges
    input wire logic ref_edge,
    input wire logic div_edge,
    // status and pins
    output logic lock_detect,
    output logic lock_or_serial_out_pin,
    output logic gpo_test_out
);
    // ==========================================
    // serial port
    logic wr_pulse;
    logic [5:0] ser_addr;
    logic [23:0] ser_wdata;
    logic rd_active;
    logic ser_sdo;
    logic [23:0] ld_ctrl_r, ld_ctrl_nxt;
    logic [23:0] pin_cfg_r, pin_cfg_nxt;
    logic lock_r, lock_nxt;
    logic [23:0] rdata;

    assign rdata = plld_read(ser_addr, ld_ctrl_r, pin_cfg_r, lock_r);

    plld_serial_port u_port (
        .clock(clock),
        .nrst(nrst),
        .ser_clk(ser_clk),
        .ser_en(ser_en),
        .ser_din(ser_din),
        .rdata(rdata),
        .wr_pulse(wr_pulse),
        .addr(ser_addr),
        .wdata(ser_wdata),
        .rd_active(rd_active),
        .sdo(ser_sdo)
    );

    // ==========================================
    // registers
    always_comb begin
        ld_ctrl_nxt = ld_ctrl_r;
        pin_cfg_nxt = pin_cfg_r;
        if (wr_pulse && ser_addr == REG_LD_CTRL) begin
            ld_ctrl_nxt = ser_wdata & CTRL_RW_MASK;
        end
        if (wr_pulse && ser_addr == REG_PIN_CFG) begin
            pin_cfg_nxt = ser_wdata & PIN_RW_MASK;
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            ld_ctrl_r <= LD_CTRL_RST;
            pin_cfg_r <= PIN_CFG_RST;
        end else begin
            ld_ctrl_r <= ld_ctrl_nxt;
            pin_cfg_r <= pin_cfg_nxt;
        end
    end

    logic ld_en, wtype, share;
    logic [2:0] thr_code, dur;
    logic [1:0] spd;
    logic [4:0] pin_src;
    assign ld_en = ld_ctrl_r[EN_BIT];
    assign wtype = ld_ctrl_r[WTYPE_BIT];
    assign thr_code = ld_ctrl_r[THR_LSB +: 3];
    assign dur = ld_ctrl_r[DUR_LSB +: 3];
    assign spd = ld_ctrl_r[SPD_LSB +: 2];
    assign pin_src = pin_cfg_r[PIN_SRC_LSB +: 5];
    assign share = pin_cfg_r[PIN_SHARE_BIT];

    // ==========================================
    // ld timer clock (stands in for the ring oscillator)
    logic [1:0] div_cnt_r, div_cnt_nxt;
    logic ld_clk_r, ld_clk_nxt;
    logic half_tick;

    always_comb begin
        half_tick = ld_en && (div_cnt_r == spd);
        div_cnt_nxt = half_tick ? 2'h0 : 2'(div_cnt_r + 2'h1);
        // ld clock toggled for test pin
        ld_clk_nxt = half_tick ? ~ld_clk_r : ld_clk_r;
        if (!ld_en) begin
            div_cnt_nxt = 2'h0;
            ld_clk_nxt = 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            div_cnt_r <= 2'h0;
            ld_clk_r <= 1'b0;
        end else begin
            div_cnt_r <= div_cnt_nxt;
            ld_clk_r <= ld_clk_nxt;
        end
    end

    // ==========================================
    // edge comparison and consecutive count
    plld_cmp_type state_r, state_nxt;
    logic [7:0] win_cnt_r, win_cnt_nxt;
    logic [16:0] run_cnt_r, run_cnt_nxt;
    logic [16:0] thr;
    logic [7:0] limit;
    logic step, hit, miss;

    always_comb begin
        thr = plld_thresh(thr_code);
        // analog fixed window or digital timer
        step = wtype ? half_tick : 1'b1;
        limit = wtype ? 8'(8'h01 << dur) : ANALOG_WIN_CYC;
        state_nxt = state_r;
        win_cnt_nxt = win_cnt_r;
        hit = 1'b0;
        miss = 1'b0;
        // whichever edge is first starts timing
        unique case (state_r)
            CMP_IDLE: begin
                win_cnt_nxt = 8'h00;
                if (ref_edge && div_edge) begin
                    hit = 1'b1;
                end else if (ref_edge) begin
                    state_nxt = CMP_WAIT_DIV;
                end else if (div_edge) begin
                    state_nxt = CMP_WAIT_REF;
                end
            end
            CMP_WAIT_DIV, CMP_WAIT_REF: begin
                if ((state_r == CMP_WAIT_DIV) ? div_edge : ref_edge) begin
                    hit = (win_cnt_r < limit);
                    miss = !hit;
                    state_nxt = CMP_IDLE;
                end else if (step) begin
                    if (8'(win_cnt_r + 8'h01) >= limit) begin
                        miss = 1'b1;
                        state_nxt = CMP_IDLE;
                    end else begin
                        win_cnt_nxt = 8'(win_cnt_r + 8'h01);
                    end
                end
            end
            default: begin
                state_nxt = CMP_IDLE;
            end
        endcase
        run_cnt_nxt = run_cnt_r;
        lock_nxt = lock_r;
        if (hit) begin
            if (run_cnt_r < thr) begin
                run_cnt_nxt = 17'(run_cnt_r + 17'h00001);
            end
            if (17'(run_cnt_r + 17'h00001) >= thr) begin
                lock_nxt = 1'b1;
            end
        end
        // miss restarts count and drops lock
        if (miss) begin
            run_cnt_nxt = 17'h00000;
            lock_nxt = 1'b0;
        end
        if (!ld_en) begin
            state_nxt = CMP_IDLE;
            win_cnt_nxt = 8'h00;
            run_cnt_nxt = 17'h00000;
            lock_nxt = 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            state_r <= CMP_IDLE;
            win_cnt_r <= 8'h00;
            run_cnt_r <= 17'h00000;
            lock_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            win_cnt_r <= win_cnt_nxt;
            run_cnt_r <= run_cnt_nxt;
            lock_r <= lock_nxt;
        end
    end

    // ==========================================
    // shared pin; registered so the pin never glitches on a mux change
    logic pin_r, pin_nxt;

    always_comb begin
        pin_nxt = 1'b0;
        if (rd_active && !share) begin
            pin_nxt = ser_sdo;
        // lock shown when source selects it
        end else if (pin_src == PIN_SRC_LOCK) begin
            pin_nxt = lock_r;
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            pin_r <= 1'b0;
        end else begin
            pin_r <= pin_nxt;
        end
    end

    assign lock_detect = lock_r;
    assign lock_or_serial_out_pin = pin_r;
    assign gpo_test_out = ld_clk_r;

    // ==========================================
    // checks
    a_disable_clears: assert property (@(posedge clock) disable iff (!nrst)
        !ld_en |=> (!lock_r && run_cnt_r == 17'h00000))
        else $error("lock state not cleared while disabled");

    a_enable_at_reset: assert property (@(posedge clock)
        !nrst |=> (ld_ctrl_r[EN_BIT] && ld_ctrl_r == LD_CTRL_RST))
        else $error("control register not at reset value");

    a_miss_clears: assert property (@(posedge clock) disable iff (!nrst)
        (ld_en && miss) |=> (!lock_r && run_cnt_r == 17'h00000))
        else $error("miss did not restart count");

    a_lock_threshold: assert property (@(posedge clock) disable iff (!nrst)
        ($rose(lock_r) && $stable(thr_code)) |-> (run_cnt_r >= thr))
        else $error("lock before threshold reached");

    a_digital_window: assert property (@(posedge clock) disable iff (!nrst)
        (ld_en && wtype && state_r != CMP_IDLE && $stable(dur))
        |-> (win_cnt_r < limit))
        else $error("digital window count exceeded limit");

    a_analog_window: assert property (@(posedge clock) disable iff (!nrst)
        (ld_en && !wtype && state_r == CMP_IDLE && ref_edge && !div_edge)
        ##1 (ld_en && !wtype && !div_edge) |=> (run_cnt_r == 17'h00000))
        else $error("late edge counted inside analog window");

    a_either_order: assert property (@(posedge clock) disable iff (!nrst)
        (ld_en && state_r == CMP_IDLE && div_edge && !ref_edge)
        |=> (state_r == CMP_WAIT_REF))
        else $error("divided edge first did not start timing");

    a_speed_div: assert property (@(posedge clock) disable iff (!nrst)
        (ld_en && spd != 2'h0 && half_tick) ##1 (ld_en && $stable(spd)) |-> !half_tick)
        else $error("ld timer ran too fast for speed code");

    a_test_clock: assert property (@(posedge clock) disable iff (!nrst)
        (ld_en && half_tick) |=> (gpo_test_out != $past(gpo_test_out)))
        else $error("test pin did not follow ld clock");

    a_pin_lock: assert property (@(posedge clock) disable iff (!nrst)
        (!rd_active && pin_src == PIN_SRC_LOCK) |=> (pin_r == $past(lock_r)))
        else $error("pin does not show lock flag");

    a_pin_serial: assert property (@(posedge clock) disable iff (!nrst)
        (rd_active && !share) |=> (pin_r == $past(ser_sdo)))
        else $error("pin does not carry serial data during read");
endmodule

// >>> sim/plld_host_model.sv
// host controller model: sends serial frames, takes read data off the shared pin.
// assumes one caller at a time; the serial clock stands low outside frames.
`timescale 1ns/10ps
module plld_host_model (
    // clock
    input wire logic clock,
    // serial pins
    output logic ser_clk,
    output logic ser_en,
    output logic ser_din,
    input wire logic sdo
);
    initial begin
        ser_clk = 1'b0;
        ser_en = 1'b0;
        ser_din = 1'b0;
    end

    // ==========================================
    // frame: rw, 6 address bits, 24 data bits, msb first
    // window codes chosen by caller
    task automatic xfer(input logic rw, input logic [5:0] addr, input logic [23:0] wd,
                        output logic [23:0] rd);
        logic [30:0] frm;
        frm = {rw, addr, wd};
        rd = 24'h000000;
        @(negedge clock);
        ser_en = 1'b1;
        for (int i = 30; i >= 0; i--) begin
            ser_clk = 1'b0;
            ser_din = frm[i];
            repeat (2) @(negedge clock);
            // pin settles by the first clock of the low half, so sample just before the rise
            if (i < 24) rd[i] = sdo;
            ser_clk = 1'b1;
            repeat (2) @(negedge clock);
        end
        ser_clk = 1'b0;
        ser_en = 1'b0;
        // released line: no stale bit left on it
        ser_din = ~ser_din;
        repeat (4) @(negedge clock);
    endtask
endmodule

// >>> sim/tb_top.sv
// bench for the lock detector: register frames, phase edge pairs, pin checks.
// assumes the host model drives the serial pins; edges are driven here.
`timescale 1ns/10ps
module tb_top
    import plld_pkg::*;
;
    logic clock;
    logic nrst;
    logic ref_edge;
    logic div_edge;
    wire ser_clk;
    wire ser_en;
    wire ser_din;
    wire lock_detect;
    wire ld_pin;
    wire gpo;
    int fail_count = 0;
    int num_checks = 0;
    logic [23:0] rd;
    int n;

    plld_lock_detect i_dut (
        .clock(clock), .nrst(nrst), .ser_clk(ser_clk), .ser_en(ser_en),
        .ser_din(ser_din), .ref_edge(ref_edge), .div_edge(div_edge),
        .lock_detect(lock_detect), .lock_or_serial_out_pin(ld_pin), .gpo_test_out(gpo)
    );
    plld_host_model i_host (
        .clock(clock), .ser_clk(ser_clk), .ser_en(ser_en), .ser_din(ser_din), .sdo(ld_pin)
    );

    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    // ==========================================
    // helpers
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic rreg(input logic [5:0] a, output logic [23:0] d);
        i_host.xfer(1'b1, a, 24'h000000, d);
    endtask

    task automatic wreg(input logic [5:0] a, input logic [23:0] d);
        logic [23:0] dummy;
        i_host.xfer(1'b0, a, d, dummy);
    endtask

    task automatic cfg(input logic [2:0] thr, input logic wt, input logic [2:0] dur,
                       input logic [1:0] spd, input logic en);
        wreg(REG_LD_CTRL, {12'h000, spd, dur, wt, 2'b00, en, thr});
    endtask

    // gap < 0: opening edge only, so the comparison times out
    task automatic pair(input int gap, input bit div_first);
        @(negedge clock);
        ref_edge = (gap == 0) || !div_first;
        div_edge = (gap == 0) || div_first;
        @(negedge clock);
        ref_edge = 1'b0;
        div_edge = 1'b0;
        if (gap > 0) begin
            repeat (gap - 1) @(negedge clock);
            ref_edge = div_first;
            div_edge = !div_first;
            @(negedge clock);
            ref_edge = 1'b0;
            div_edge = 1'b0;
        end
        // longer than any window that times out here (16 clocks at most), late edges included
        repeat (30) @(negedge clock);
    endtask

    task automatic burst(input int cnt, input int gap);
        for (int i = 0; i < cnt; i++) pair(gap, i[0]);
    endtask

    task automatic toggles(input int cyc, output int t);
        logic last;
        t = 0;
        last = gpo;
        repeat (cyc) begin
            @(negedge clock);
            if (gpo !== last) t++;
            last = gpo;
        end
    endtask

    // ==========================================
    // scenarios
    task automatic t_reset();
        chk(24'(lock_detect), 24'h000000);
        chk(24'(ld_pin), 24'h000000);
        rreg(REG_LD_CTRL, rd);
        chk(rd, 24'h00014d);
        rreg(REG_PIN_CFG, rd);
        chk(rd, 24'h000001);
        rreg(REG_STATUS, rd);
        chk(rd, 24'h000000);
        rreg(6'h20, rd);
        chk(rd, 24'h000000);
        wreg(REG_STATUS, 24'hffffff);
        rreg(REG_STATUS, rd);
        chk(rd, 24'h000000);
        wreg(REG_LD_CTRL, 24'hffffff);
        rreg(REG_LD_CTRL, rd);
        chk(rd, 24'h000fcf);
    endtask

    task automatic t_lock();
        cfg(3'h0, 1'b1, 3'h3, 2'h1, 1'b1);
        burst(4, 4);
        chk(24'(lock_detect), 24'h000000);
        burst(1, 4);
        chk(24'(lock_detect), 24'h000001);
        rreg(REG_STATUS, rd);
        chk(rd, 24'h000002);
        chk(24'(ld_pin), 24'h000001);
        pair(-1, 1'b0);
        chk(24'(lock_detect), 24'h000000);
        burst(4, 4);
        chk(24'(lock_detect), 24'h000000);
        burst(1, 4);
        chk(24'(lock_detect), 24'h000001);
        cfg(3'h1, 1'b1, 3'h3, 2'h1, 1'b1);
        pair(-1, 1'b0);
        burst(31, 0);
        chk(24'(lock_detect), 24'h000000);
        burst(1, 0);
        chk(24'(lock_detect), 24'h000001);
    endtask

    task automatic t_window();
        // gap of 10 clocks: fits once the window is 8 half ticks of 2+ clocks
        for (int s = 0; s < 4; s++) begin
            cfg(3'h0, 1'b1, 3'h3, 2'(s), 1'b1);
            burst(5, 10);
            chk(24'(lock_detect), (s > 0) ? 24'h000001 : 24'h000000);
            // half tick every speed+1 clocks, so 24 clocks give an exact count
            toggles(24, n);
            chk(24'(n), 24'(24 / (s + 1)));
        end
        for (int d = 0; d < 8; d++) begin
            cfg(3'h0, 1'b1, 3'(d), 2'h1, 1'b1);
            burst(5, 10);
            chk(24'(lock_detect), (d > 2) ? 24'h000001 : 24'h000000);
        end
        cfg(3'h0, 1'b1, 3'h0, 2'h0, 1'b1);
        burst(5, 0);
        chk(24'(lock_detect), 24'h000001);
        pair(2, 1'b1);
        chk(24'(lock_detect), 24'h000000);
    endtask

    task automatic t_analog();
        cfg(3'h0, 1'b0, 3'h3, 2'h1, 1'b1);
        burst(5, 0);
        chk(24'(lock_detect), 24'h000001);
        pair(3, 1'b0);
        chk(24'(lock_detect), 24'h000000);
    endtask

    task automatic t_disable();
        cfg(3'h0, 1'b1, 3'h3, 2'h1, 1'b1);
        burst(5, 0);
        toggles(40, n);
        chk(24'(n >= 19 && n <= 21), 24'h000001);
        cfg(3'h0, 1'b1, 3'h3, 2'h1, 1'b0);
        chk(24'(lock_detect), 24'h000000);
        toggles(40, n);
        chk(24'(n), 24'h000000);
        burst(5, 0);
        chk(24'(lock_detect), 24'h000000);
        cfg(3'h0, 1'b1, 3'h3, 2'h1, 1'b1);
        burst(4, 0);
        chk(24'(lock_detect), 24'h000000);
        burst(1, 0);
        chk(24'(lock_detect), 24'h000001);
    endtask

    task automatic t_pin();
        rreg(REG_STATUS, rd);
        chk(rd, 24'h000002);
        chk(24'(ld_pin), 24'h000001);
        wreg(REG_PIN_CFG, 24'h000041);
        rreg(REG_STATUS, rd);
        chk(rd, 24'hffffff);
        wreg(REG_PIN_CFG, 24'h000002);
        chk(24'(ld_pin), 24'h000000);
        rreg(REG_PIN_CFG, rd);
        chk(rd, 24'h000002);
        wreg(REG_PIN_CFG, 24'h000001);
        chk(24'(ld_pin), 24'h000001);
    endtask

    // ==========================================
    // main sequence
    initial begin
        nrst = 1'b0;
        ref_edge = 1'b0;
        div_edge = 1'b0;
        repeat (3) @(posedge clock);
        @(negedge clock);
        nrst = 1'b1;
        t_reset();
        t_lock();
        t_window();
        t_analog();
        t_disable();
        t_pin();
        give_verdict();
    end

    // about six times the expected run of the sequence above
    initial begin
        repeat (60000) @(posedge clock);
        fail_count++;
        give_verdict();
    end
endmodule
